// file: hdl/sacc_pkg.sv
// sacc_pkg: constants, register map and types of the conversion sequencer.
// assumes a classic wishbone slave with 32-bit data and byte addresses.
// Overview of operation
// R1 - trigger 0 and run 1: start at once
// R2 - channel select bits 1..3 choose input
// R3 - completion loads result and raises interrupt
// R4 - software mode repeats conversions back to back
// R5 - run-set write mid-conversion restarts with new settings
// R6 - run-clear write stops conversion immediately
// R7 - halts in stop or subsystem-clock halt
// R8 - mode write never clears done flag
// R9 - completion just before rewrite still sets flag
// R10 - software clears flag before restarting
// R11 - software avoids port-1 reads during conversion
// R12 - result is unsigned eight bits
// R13 - trigger and run 1: one conversion per edge
// R14 - successive approximation msb first to bit 0
// R15 - flag sticky until software clears it
package sacc_pkg;
    // register byte offsets
    localparam logic [3:0] MODE_OFFS = 4'h0; // converter_mode_reg
    localparam logic [3:0] RESULT_OFFS = 4'h4; // conversion_result_reg
    localparam logic [3:0] STATUS_OFFS = 4'h8; // sticky event status, write one to clear
    localparam logic [3:0] MASK_OFFS = 4'hC; // interrupt mask
    // mode register fields
    localparam int MODE_RUN_BIT = 7; // conversion run
    localparam int MODE_TRG_BIT = 6; // trigger_select
    localparam int MODE_CH_LSB = 1; // channel_select_bits low end
    localparam int MODE_CH_MSB = 3; // channel_select_bits high end
    // status fields
    localparam int STAT_DONE_BIT = 0; // conversion_done_flag
    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [0:0] MASK_RESET = 1'h0;
    // timing: sampling time before the first comparison, in ns
    localparam int SAMPLE_TIME_NS = 200;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, // stopped
        ST_WAIT = 2'b01, // hardware-start standby
        ST_SAMPLE = 2'b10, // sample and hold
        ST_CONVERT = 2'b11 // bit decisions
    } sacc_state_type;
endpackage : sacc_pkg

// file: hdl/sacc_sar.sv
// sacc_sar: successive approximation register, one bit decided per step.
// assumes the comparator answer settles within the cycle the tap is shown.
`timescale 1ns/1ps
module sacc_sar #(
    parameter int WIDTH = 8 // result width
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic start, // load msb trial
    input wire logic abort, // drop the conversion
    input wire logic comp_hi, // input at or above tap
    output logic [WIDTH-1:0] tap, // trial code to the resistor string
    output logic done // pulse: last bit decided
);
    logic [WIDTH-1:0] sar_q; // approximation_register
    logic [WIDTH-1:0] mask_q; // bit under trial, one hot
    logic [WIDTH-1:0] keep; // trial after the decision
    logic [WIDTH-1:0] next_trial; // trial with next bit set
    logic busy_q; // a conversion is stepping

    // a one-bit register has no successive steps to take
    if (WIDTH < 2) begin : g_width_check
        $error("sacc_sar: WIDTH must be at least 2");
    end

    assign keep = comp_hi ? sar_q : (sar_q & ~mask_q);
    assign next_trial = keep | (mask_q >> 1);
    assign tap = sar_q;
    assign done = busy_q && mask_q[0];

    // step one bit per clock from msb down to bit 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sar_q <= '0;
            mask_q <= '0;
            busy_q <= 1'b0;
        end else if (abort) begin
            busy_q <= 1'b0;
        end else if (start) begin
            sar_q <= {1'b1, {(WIDTH-1){1'b0}}}; // R14
            mask_q <= {1'b1, {(WIDTH-1){1'b0}}};
            busy_q <= 1'b1;
        end else if (busy_q) begin
            sar_q <= next_trial; // R14
            mask_q <= mask_q >> 1;
            busy_q <= !mask_q[0];
        end
    end
endmodule : sacc_sar

// file: hdl/sacc_ctrl.sv
// sacc_ctrl: conversion sequencer with a classic wishbone register slave.
// assumes the analog sample-and-hold and comparator sit outside and settle
// COMP_HI within the cycle ANALOG_TAP is shown; trigger edge is synchronous.
`timescale 1ns/1ps
module sacc_ctrl
    import sacc_pkg::*;
#(
    parameter int RES_BITS = 8 // result width, fixed by the register
) (
    input wire logic CLK_SYS, // 50 MHz main system clock
    input wire logic RST_N, // async reset, active low
    input wire logic [3:0] WB_ADR_I, // byte address
    input wire logic [31:0] WB_DAT_I, // write data
    output logic [31:0] WB_DAT_O, // read data
    input wire logic WB_WE_I, // write enable
    input wire logic [3:0] WB_SEL_I, // byte lanes
    input wire logic WB_CYC_I, // cycle
    input wire logic WB_STB_I, // strobe
    output logic WB_ACK_O, // acknowledge
    output logic WB_ERR_O, // unmapped address
    input wire logic STOP_MODE, // chip in stop mode
    input wire logic SUB_HALT, // halt with subsystem clock
    input wire logic EXTERNAL_TRIGGER_INPUT, // hardware start trigger
    input wire logic COMP_HI, // comparator: input at or above tap
    output logic [2:0] ANALOG_INPUTS_SEL, // selected analog_inputs channel
    output logic SAMPLE_EN, // sample-and-hold tracking
    output logic [7:0] ANALOG_TAP, // tap code to the resistor string
    output logic CONVERSION_DONE_IRQ // level interrupt
);
    // the result register is eight bits wide, so no other width is served
    if (RES_BITS != 8) begin : g_width_check
        $error("sacc_ctrl: RES_BITS must be 8");
    end

    sacc_state_type state_q, state_d; // sequencer state
    logic [7:0] mode_q; // converter_mode_reg
    logic [7:0] result_q; // conversion_result_reg
    logic done_flag_q; // conversion_done_flag, sticky
    logic [0:0] mask_q; // interrupt mask
    logic [7:0] samp_cnt_q; // sampling cycle count
    logic trig_q; // last trigger level for edge detection
    logic ack_q; // bus acknowledge
    logic err_q; // bus error
    logic [31:0] rdata_q; // read data register

    // bus decode
    wire req = WB_CYC_I && WB_STB_I && !ack_q && !err_q; // fresh request
    wire hit_mode = (WB_ADR_I == MODE_OFFS);
    wire hit_res = (WB_ADR_I == RESULT_OFFS);
    wire hit_stat = (WB_ADR_I == STATUS_OFFS);
    wire hit_mask = (WB_ADR_I == MASK_OFFS);
    wire hit_any = hit_mode || hit_res || hit_stat || hit_mask;
    wire wr_ok = req && WB_WE_I && WB_SEL_I[0];
    wire mode_wr = wr_ok && hit_mode; // a write to the mode register
    wire stat_clr = wr_ok && hit_stat && WB_DAT_I[STAT_DONE_BIT];
    wire [7:0] new_mode = WB_DAT_I[7:0];

    // operating conditions
    wire halted = STOP_MODE || SUB_HALT; // R7
    wire run = mode_q[MODE_RUN_BIT];
    wire hw_trig = mode_q[MODE_TRG_BIT];
    wire trig_edge = EXTERNAL_TRIGGER_INPUT && !trig_q; // rising edge
    wire samp_last = (samp_cnt_q == 8'(SAMPLE_CYCLES - 1));

    // successive approximation core
    logic sar_start;
    logic sar_abort;
    logic sar_done;
    logic [7:0] sar_code;

    assign sar_start = (state_q == ST_SAMPLE) && samp_last && !mode_wr && !halted;
    assign sar_abort = mode_wr || halted || !run; // R5 R6

    sacc_sar #(
        .WIDTH(8)
    ) u_sar (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .start(sar_start),
        .abort(sar_abort),
        .comp_hi(COMP_HI),
        .tap(sar_code),
        .done(sar_done)
    );

    // a completion counts only if no mode write or halt cuts it off this cycle
    wire conv_end = sar_done && (state_q == ST_CONVERT) && !sar_abort;

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (run && !halted) begin
                    state_d = hw_trig ? ST_WAIT : ST_SAMPLE; // R1 R13
                end
            end
            ST_WAIT: begin
                if (trig_edge) begin
                    state_d = ST_SAMPLE; // R13
                end
            end
            ST_SAMPLE: begin
                if (samp_last) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (conv_end) begin
                    // software mode runs again at once, hardware waits
                    state_d = hw_trig ? ST_WAIT : ST_SAMPLE; // R4 R13
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // a mode write restarts from scratch with the new settings
        if (mode_wr) begin
            if (new_mode[MODE_RUN_BIT]) begin
                state_d = new_mode[MODE_TRG_BIT] ? ST_WAIT : ST_SAMPLE; // R5
            end else begin
                state_d = ST_IDLE; // R6
            end
        end
        if (halted) begin
            state_d = ST_IDLE; // R7
        end
    end

    // sequencer registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            trig_q <= 1'b0;
        end else begin
            state_q <= state_d;
            trig_q <= EXTERNAL_TRIGGER_INPUT;
        end
    end

    // sampling counter restarts on every entry to the sample state
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            samp_cnt_q <= 8'h00;
        end else if (state_q != ST_SAMPLE || mode_wr) begin
            samp_cnt_q <= 8'h00;
        end else if (!samp_last) begin
            samp_cnt_q <= samp_cnt_q + 8'h01;
        end
    end

    // mode register; writing it leaves the done flag alone
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_q <= MODE_RESET;
        end else if (mode_wr) begin
            mode_q <= new_mode; // R8
        end
    end

    // result register loads with the unsigned eight-bit code
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            result_q <= RESULT_RESET;
        end else if (conv_end) begin
            result_q <= {sar_code[7:1], COMP_HI ? sar_code[0] : 1'b0}; // R3 R12
        end
    end

    // done flag: set wins over software clear, stays set until cleared
    // the ending conversion from before a mode write still sets it
    wire flag_set = sar_done && (state_q == ST_CONVERT) && !halted; // R9
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            done_flag_q <= 1'b0;
        end else if (flag_set) begin
            done_flag_q <= 1'b1; // R3 R15
        end else if (stat_clr) begin
            done_flag_q <= 1'b0; // R10
        end
    end

    // interrupt mask
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mask_q <= MASK_RESET;
        end else if (wr_ok && hit_mask) begin
            mask_q <= WB_DAT_I[0:0];
        end
    end

    // read mux
    wire [31:0] rd_mux = hit_mode ? {24'h000000, mode_q} :
                         hit_res ? {24'h000000, result_q} :
                         hit_stat ? {31'h00000000, done_flag_q} :
                         hit_mask ? {31'h00000000, mask_q} : 32'h00000000;

    // bus answer one cycle after the request, dropped the cycle after
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= req && hit_any;
            err_q <= req && !hit_any;
            if (req && !WB_WE_I) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // outputs
    assign WB_ACK_O = ack_q;
    assign WB_ERR_O = err_q;
    assign WB_DAT_O = rdata_q;
    assign ANALOG_INPUTS_SEL = mode_q[MODE_CH_MSB:MODE_CH_LSB]; // R2
    assign SAMPLE_EN = (state_q == ST_SAMPLE);
    assign ANALOG_TAP = sar_code;
    assign CONVERSION_DONE_IRQ = done_flag_q && mask_q[0]; // R3
endmodule : sacc_ctrl

// file: verification/sacc_analog_model.sv
// sacc_analog_model: sample-and-hold and comparator facing the sequencer.
// assumes each channel carries a fixed level known to the bench.
`timescale 1ns/1ps
module sacc_analog_model (
    input wire logic clk, // system clock
    input wire logic [2:0] sel, // selected channel
    input wire logic sample_en, // track while high
    input wire logic [7:0] tap, // trial code
    output logic comp_hi // held level at or above tap
);
    logic [7:0] held_q = 8'h00; // held input level
    // the comparator settles within the cycle in which the tap is shown,
    // since the sequencer decides each bit at the end of that same cycle
    assign comp_hi = held_q >= tap;
    // track while sampling, then hold through the bit decisions
    always @(posedge clk) begin
        if (sample_en) begin
            held_q <= 8'h17 * ({5'h00, sel} + 8'h01) + 8'h05; // per-channel level
        end
    end
endmodule : sacc_analog_model

// file: verification/sacc_ctrl_checker.sv
// sacc_ctrl_checker: bus and sequencer properties at the controller ports.
// assumes the top module ports only; attached by bind below.
`timescale 1ns/1ps
module sacc_ctrl_checker
    import sacc_pkg::*;
(
    input wire logic CLK_SYS, // clock
    input wire logic RST_N, // reset
    input wire logic [3:0] WB_ADR_I, // address
    input wire logic [31:0] WB_DAT_I, // write data
    input wire logic WB_WE_I, // write
    input wire logic [3:0] WB_SEL_I, // lanes
    input wire logic WB_CYC_I, // cycle
    input wire logic WB_STB_I, // strobe
    input wire logic WB_ACK_O, // ack
    input wire logic WB_ERR_O, // error
    input wire logic STOP_MODE, // stop
    input wire logic SUB_HALT, // halt
    input wire logic [2:0] ANALOG_INPUTS_SEL, // channel
    input wire logic SAMPLE_EN, // sampling
    input wire logic [7:0] ANALOG_TAP, // trial code
    input wire logic CONVERSION_DONE_IRQ // interrupt
);
    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // fresh request, and which places it hits
    wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
    wire logic mapped = WB_ADR_I[1:0] == 2'h0;
    wire logic mode_req = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == MODE_OFFS;
    wire logic mode_wr = mode_req && WB_ACK_O && WB_SEL_I[0];
    wire logic flag_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I[3];
    a_ack_mapped: assert property (req && mapped |=> WB_ACK_O && !WB_ERR_O)
        else $error("mapped access not acked");
    a_err_unmapped: assert property (req && !mapped |=> WB_ERR_O && !WB_ACK_O)
        else $error("unmapped access not refused");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_sel_loads: assert property (mode_wr |-> ANALOG_INPUTS_SEL == WB_DAT_I[3:1])
        else $error("channel select not loaded");
    a_sw_starts: assert property (mode_wr && WB_DAT_I[7:6] == 2'h2
        && !$past(STOP_MODE || SUB_HALT) |-> SAMPLE_EN) else $error("no immediate start");
    // a mode write or halt cuts the phase short, so it ends the attempt
    a_sample_len: assert property (disable iff (!RST_N || mode_req || STOP_MODE || SUB_HALT)
        $rose(SAMPLE_EN) |-> SAMPLE_EN[*8] ##1 SAMPLE_EN[*2] ##1
        (!SAMPLE_EN && ANALOG_TAP == 8'h80)) else $error("sample phase or msb trial wrong");
    a_halt_idle: assert property (STOP_MODE || SUB_HALT |=> !SAMPLE_EN)
        else $error("converter runs in halt");
    a_irq_sticky: assert property (CONVERSION_DONE_IRQ && !flag_wr |=> CONVERSION_DONE_IRQ)
        else $error("interrupt dropped without a clear");
    c_err: cover property (WB_ERR_O);
    c_irq: cover property ($rose(CONVERSION_DONE_IRQ));
    c_sample: cover property ($rose(SAMPLE_EN));
endmodule : sacc_ctrl_checker
bind sacc_ctrl sacc_ctrl_checker sacc_ctrl_checker_inst (.*);

// file: verification/tb_top.sv
// tb_top: register level bench for the conversion sequencer.
// assumes the analog model levels and a one-cycle bus answer.
`timescale 1ns/1ps
module tb_top;
    import sacc_pkg::*;
    logic clk = 1'b0; // system clock
    logic rst_n = 1'b0; // reset
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, stop = 1'b0, halt = 1'b0, trig = 1'b0;
    logic [3:0] adr = 4'h0; // address
    logic [31:0] wdat = 32'h0, rdat, q; // bus data
    logic ack, err, e, comp, smp, irq; // design answers
    logic [2:0] chsel; // channel
    logic [7:0] tap; // trial code
    int miscompares = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    sacc_ctrl sacc_ctrl_inst (.CLK_SYS(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_ACK_O(ack), .WB_ERR_O(err), .STOP_MODE(stop), .SUB_HALT(halt),
        .EXTERNAL_TRIGGER_INPUT(trig), .COMP_HI(comp), .ANALOG_INPUTS_SEL(chsel),
        .SAMPLE_EN(smp), .ANALOG_TAP(tap), .CONVERSION_DONE_IRQ(irq));
    sacc_analog_model sacc_analog_model_inst (.clk(clk), .sel(chsel), .sample_en(smp),
        .tap(tap), .comp_hi(comp));
    function automatic logic [31:0] lvl(input logic [2:0] c);
        return {24'h0, 8'h17 * ({5'h00, c} + 8'h01) + 8'h05};
    endfunction : lvl
    task automatic finish_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one classic cycle, held until ack or err is sampled high
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            finish_test();
        end
        {q, e} = {rdat, err};
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic wait_irq(input int lim);
        int k;
        for (k = 0; irq !== 1'b1 && k < lim; k++) @(posedge clk);
        if (irq !== 1'b1) begin
            miscompares++;
            finish_test();
        end
    endtask : wait_irq
    initial begin
        idle(10);
        rst_n <= 1'b1;
        bus(0, RESULT_OFFS, 0);
        chk("result reset", q, {24'h0, RESULT_RESET});
        bus(0, 4'h2, 0);
        chk("unmapped", e, 1);
        bus(1, MODE_OFFS, 32'h80);
        idle(25);
        chk("masked irq", irq, 0);
        bus(1, MASK_OFFS, 1);
        idle(1);
        chk("unmasked irq", irq, 1);
        $display("test reset_mask done");
        // results are read only once stopped, never while converting
        for (int c = 0; c < 8; c++) begin
            bus(1, MODE_OFFS, 32'h80 + 2 * c);
            bus(1, STATUS_OFFS, 1);
            wait_irq(40);
            bus(1, MODE_OFFS, 0);
            bus(0, RESULT_OFFS, 0);
            chk("result", q, lvl(c));
            bus(0, STATUS_OFFS, 0);
            chk("flag after mode write", q[0], 1);
            bus(1, STATUS_OFFS, 1);
            idle(1);
            chk("irq cleared", irq, 0);
        end
        $display("test channels done");
        bus(1, MODE_OFFS, 32'h84);
        wait_irq(40);
        bus(1, STATUS_OFFS, 1);
        wait_irq(19);
        bus(1, STATUS_OFFS, 1);
        bus(1, MODE_OFFS, 32'h82);
        idle(12);
        bus(1, MODE_OFFS, 32'h8C);
        idle(10);
        chk("no old completion", irq, 0);
        wait_irq(22);
        bus(1, MODE_OFFS, 0);
        bus(0, RESULT_OFFS, 0);
        chk("restart result", q, lvl(6));
        $display("test repeat_restart done");
        bus(1, STATUS_OFFS, 1);
        bus(1, MODE_OFFS, 32'h84);
        idle(12);
        bus(1, MODE_OFFS, 0);
        idle(25);
        chk("stopped irq", irq, 0);
        for (int h = 0; h < 2; h++) begin
            bus(1, MODE_OFFS, 32'h84);
            idle(12);
            {stop, halt} <= (h == 0) ? 2'b10 : 2'b01;
            idle(25);
            chk("halted irq", irq, 0);
            {stop, halt} <= 2'b00;
            bus(1, MODE_OFFS, 0);
            bus(1, STATUS_OFFS, 1);
        end
        $display("test stop_halt done");
        bus(1, MODE_OFFS, 32'hC6);
        idle(30);
        chk("no trigger", irq, 0);
        trig <= 1'b1;
        idle(1);
        trig <= 1'b0;
        wait_irq(25);
        bus(0, RESULT_OFFS, 0);
        chk("trigger result", q, lvl(3));
        bus(1, STATUS_OFFS, 1);
        idle(40);
        chk("one per trigger", irq, 0);
        $display("test hardware_start done");
        finish_test();
    end
endmodule : tb_top
